// ---- core/cwwt_cnt_if.sv ----
`timescale 1ns/10ps
// link between sequencer and its wait counter
interface cwwt_cnt_if;
  logic start;
  logic [10:0] length;
  logic busy;
  logic done;
  modport ctrl (output start, output length, input busy, input done);
  modport cnt (input start, input length, output busy, output done);
endinterface : cwwt_cnt_if

// ---- core/cwwt_counter.sv ----
`timescale 1ns/10ps
// counts a given number of cycles after a start pulse
module cwwt_counter (
  input wire logic clk_i,
  input wire logic arst_n_i,
  cwwt_cnt_if.cnt cnt_if
);
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic [10:0] len_r;
  logic [10:0] len_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;

  // a start always wins, even mid-wait, so a new wake restarts from zero
  always_comb begin
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (cnt_if.start) begin
      cnt_nxt = cwwt_pkg::CNT_RST;
      len_nxt = cnt_if.length;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (cnt_r == len_r - 11'h0001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 11'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= cwwt_pkg::CNT_RST;
      len_r <= cwwt_pkg::LONG_CYCLES;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign cnt_if.busy = busy_r;
  assign cnt_if.done = done_r;
endmodule : cwwt_counter

// ---- core/cwwt_pkg.sv ----
package cwwt_pkg;
  // wait lengths as powers of two of main oscillator periods
  localparam int unsigned LONG_EXP = 10;
  localparam int unsigned SHORT_EXP = 3;
  localparam int unsigned CNT_W = 11;
  localparam logic [10:0] LONG_CYCLES = 11'h0400;
  localparam logic [10:0] SHORT_CYCLES = 11'h0008;
  localparam logic [10:0] CNT_RST = 11'h0000;
  // main oscillator period in ns, clock period in ns
  localparam int unsigned OSC_PERIOD_NS = 20;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CYC_PER_OSC = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // target operating mode after wake-up
  typedef enum logic {
    CWWT_TGT_NORMAL,
    CWWT_TGT_SLOW
  } cwwt_target_t;
  // source mode left on wake-up
  typedef enum logic [1:0] {
    CWWT_SRC_STOP,
    CWWT_SRC_CPU_IDLE,
    CWWT_SRC_LOW_CLK_IDLE,
    CWWT_SRC_NONE
  } cwwt_source_t;
endpackage : cwwt_pkg

// ---- core/cwwt_wait_timer.sv ----
`timescale 1ns/10ps
module cwwt_wait_timer #(
  parameter int unsigned LONG_EXP = cwwt_pkg::LONG_EXP,
  parameter int unsigned SHORT_EXP = cwwt_pkg::SHORT_EXP
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wake_i,
  input wire logic [1:0] wake_source_i,
  input wire logic wake_target_i,
  input wire logic pwdn_select_i,
  input wire logic irq_i,
  input wire logic irq_clear_i,
  input wire logic interrupt_master_enable_i,
  output logic cpu_halt_o,
  output logic periph_halt_o,
  output logic interrupt_latch_o,
  output logic irq_service_o
);
  // sequencer states, boot runs for exactly one cycle after reset release
  typedef enum logic [1:0] {
    CWWT_ST_BOOT,
    CWWT_ST_RESET_WAIT,
    CWWT_ST_RUN,
    CWWT_ST_WAKE_WAIT
  } cwwt_state_t;

  // wait lengths; the counter is cwwt_pkg::CNT_W bits, so 2^10 is the longest it times
  localparam logic [10:0] LONG_LEN = 11'(1 << LONG_EXP);
  localparam logic [10:0] SHORT_LEN = 11'(1 << SHORT_EXP);
  localparam logic [10:0] NO_WAIT = 11'h0000;

  // refuse exponents the counter cannot serve; zero would leave a wait of a single count
  if (LONG_EXP >= cwwt_pkg::CNT_W || SHORT_EXP == 0 || SHORT_EXP > LONG_EXP) begin : g_bad_exp
    $error("wait exponent out of range for the wait counter");
  end

  // the interface and the counter are built for an 11 bit count
  if (cwwt_pkg::CNT_W != 11) begin : g_bad_width
    $error("wait counter width must be 11 bits");
  end

  // one shared counter times the reset wait and every wake wait
  cwwt_cnt_if cnt_if ();

  cwwt_counter u_counter (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .cnt_if(cnt_if.cnt)
  );

  // sequencer state and the two halt flags
  cwwt_state_t state_r;
  cwwt_state_t state_nxt;
  logic cpu_halt_r;
  logic cpu_halt_nxt;
  logic periph_halt_r;
  logic periph_halt_nxt;

  // interrupt side
  logic latch_r;
  logic latch_nxt;
  logic service_r;
  logic service_nxt;

  // counter request, valid only in the cycle it is raised
  logic start_c;
  logic [10:0] len_c;

  // classify a wake: returns wait length, zero when the wake does not qualify;
  // the power-down select bit decides which source paths lead to a wait,
  // so a wake from a path that does not match it leaves the cpu running
  function automatic logic [10:0] cwwt_wake_len(input logic [1:0] src, input logic tgt,
                                                 input logic psel);
    logic [10:0] len;
    len = NO_WAIT;
    case (src)
      cwwt_pkg::CWWT_SRC_STOP: begin
        // out of stop either target is reached through the power-down path
        if (psel) begin
          len = (tgt == cwwt_pkg::CWWT_TGT_NORMAL) ? LONG_LEN
                                                    : SHORT_LEN;
        end
      end
      cwwt_pkg::CWWT_SRC_CPU_IDLE: begin
        // the idle path only waits when it returns to full speed
        if (!psel && tgt == cwwt_pkg::CWWT_TGT_NORMAL) begin
          len = LONG_LEN;
        end
      end
      cwwt_pkg::CWWT_SRC_LOW_CLK_IDLE: begin
        // the low clock path only waits when it returns to slow mode
        if (!psel && tgt == cwwt_pkg::CWWT_TGT_SLOW) begin
          len = SHORT_LEN;
        end
      end
      default: begin
        len = NO_WAIT;
      end
    endcase
    return len;
  endfunction : cwwt_wake_len

  // true when a wake event leads to a cpu wait; other combinations are ignored
  function automatic logic cwwt_wake_ok(input logic [1:0] src, input logic tgt,
                                        input logic psel);
    return cwwt_wake_len(src, tgt, psel) != NO_WAIT;
  endfunction : cwwt_wake_ok

  // wait timeline, start edge S: the counter sees start at S, counts N edges,
  // registers done at S+N, and the halt flag drops at S+N+1, so the cpu is
  // held N+1 cycles; the extra cycle keeps every halt output straight from a flop
  // wakes arriving during the reset wait are not looked at, the count runs out first
  // sequencer: first cycle after reset release starts the reset wait
  always_comb begin
    state_nxt = state_r;
    cpu_halt_nxt = cpu_halt_r;
    periph_halt_nxt = periph_halt_r;
    start_c = 1'b0;
    len_c = LONG_LEN;
    case (state_r)
      CWWT_ST_BOOT: begin
        start_c = 1'b1;
        len_c = LONG_LEN;
        state_nxt = CWWT_ST_RESET_WAIT;
      end
      CWWT_ST_RESET_WAIT: begin
        // cpu and peripherals come out together
        if (cnt_if.done) begin
          cpu_halt_nxt = 1'b0;
          periph_halt_nxt = 1'b0;
          state_nxt = CWWT_ST_RUN;
        end
      end
      CWWT_ST_RUN, CWWT_ST_WAKE_WAIT: begin
        // a fresh qualifying wake mid-wait restarts the count
        if (wake_i && cwwt_wake_ok(wake_source_i, wake_target_i, pwdn_select_i)) begin
          start_c = 1'b1;
          len_c = cwwt_wake_len(wake_source_i, wake_target_i, pwdn_select_i);
          cpu_halt_nxt = 1'b1;
          periph_halt_nxt = 1'b0;
          state_nxt = CWWT_ST_WAKE_WAIT;
        end else if (state_r == CWWT_ST_WAKE_WAIT && cnt_if.done) begin
          cpu_halt_nxt = 1'b0;
          state_nxt = CWWT_ST_RUN;
        end
      end
      default: begin
        // unreachable encoding, fall back to a full boot wait
        state_nxt = CWWT_ST_BOOT;
        cpu_halt_nxt = 1'b1;
        periph_halt_nxt = 1'b1;
      end
    endcase
  end

  // counter request straight from the sequencer decode
  assign cnt_if.start = start_c;
  assign cnt_if.length = len_c;

  // interrupt latch: set beats clear so an event in a clearing cycle is not lost
  always_comb begin
    latch_nxt = latch_r;
    if (irq_clear_i) begin
      latch_nxt = 1'b0;
    end
    // peripherals are frozen in the reset wait, so requests then are dropped
    if (irq_i && !periph_halt_r) begin
      latch_nxt = 1'b1;
    end
  end

  // service gated until cpu leaves its wait; an acceptance in flight withdraws it
  always_comb begin
    service_nxt = latch_r && interrupt_master_enable_i && !cpu_halt_r && !irq_clear_i;
  end

  // sequencer registers; reset leaves both halts raised until the boot wait ends
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= CWWT_ST_BOOT;
      cpu_halt_r <= 1'b1;
      periph_halt_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cpu_halt_r <= cpu_halt_nxt;
      periph_halt_r <= periph_halt_nxt;
    end
  end

  // latch register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // service register, a level the core polls
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      service_r <= 1'b0;
    end else begin
      service_r <= service_nxt;
    end
  end

  // every output comes straight from its flop
  assign cpu_halt_o = cpu_halt_r;
  assign periph_halt_o = periph_halt_r;
  assign interrupt_latch_o = latch_r;
  assign irq_service_o = service_r;
endmodule : cwwt_wait_timer

// ---- dv/cwwt_checker.sv ----
`timescale 1ns/10ps
// port checks for the wait timer
module cwwt_checker (
  input logic clk_i,
  input logic arst_n_i,
  input logic wake_i,
  input logic [1:0] wake_source_i,
  input logic wake_target_i,
  input logic pwdn_select_i,
  input logic irq_i,
  input logic irq_clear_i,
  input logic interrupt_master_enable_i,
  input logic cpu_halt_o,
  input logic periph_halt_o,
  input logic interrupt_latch_o,
  input logic irq_service_o
);
  logic [11:0] hcnt_r, hcnt_nxt;
  logic w_short;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // short wake from an idle core; restarts are left out of these checks
  assign w_short = wake_i && !cpu_halt_o && wake_target_i
    && wake_source_i == (pwdn_select_i ? 2'h0 : 2'h2);
  // run length of the cpu halt, zero while running
  always_comb begin
    hcnt_nxt = cpu_halt_o ? hcnt_r + 12'h001 : 12'h000;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) hcnt_r <= 12'h000;
    else hcnt_r <= hcnt_nxt;
  end
  // nine halted cycles then release
  sequence s_short_hold;
    cpu_halt_o [*8] ##1 cpu_halt_o ##1 !cpu_halt_o;
  endsequence
  property p_short_stop;
    w_short && pwdn_select_i |=> s_short_hold;
  endproperty
  a_short_stop: assert property (p_short_stop) else $error("stop wake");
  property p_short_idle;
    w_short && !pwdn_select_i |=> s_short_hold;
  endproperty
  a_short_idle: assert property (p_short_idle) else $error("idle wake");
  property p_wake_len;
    $fell(cpu_halt_o) && !$fell(periph_halt_o) |-> hcnt_r == 12'h401 || hcnt_r == 12'h009;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake len");
  property p_boot;
    $fell(periph_halt_o) |-> $fell(cpu_halt_o) && hcnt_r == 12'h402;
  endproperty
  a_boot: assert property (p_boot) else $error("boot wait");
  property p_periph;
    !periph_halt_o |=> !periph_halt_o;
  endproperty
  a_periph: assert property (p_periph) else $error("periph halt");
  property p_latch;
    irq_i && !periph_halt_o |=> interrupt_latch_o;
  endproperty
  a_latch: assert property (p_latch) else $error("latch");
  property p_svc_hold;
    cpu_halt_o && $past(cpu_halt_o) |-> !irq_service_o;
  endproperty
  a_svc_hold: assert property (p_svc_hold) else $error("early service");
  property p_svc_go;
    interrupt_latch_o && interrupt_master_enable_i && !cpu_halt_o && !irq_clear_i
      |=> irq_service_o;
  endproperty
  a_svc_go: assert property (p_svc_go) else $error("no service");
endmodule : cwwt_checker

// ---- dv/test_cwwt_wait_timer.sv ----
`timescale 1ns/10ps
module test_cwwt_wait_timer;
  logic clk_i = 0, arst_n_i = 0, wake_i = 0, wake_target_i = 0, pwdn_select_i = 0;
  logic irq_i = 0, irq_clear_i = 0, interrupt_master_enable_i = 0;
  logic [1:0] wake_source_i = 2'h0;
  logic cpu_halt_o, periph_halt_o, interrupt_latch_o, irq_service_o;
  int num_errors = 0, n_tests = 0, hc = 0, exp_q[$];
  logic m_lat = 0, m_svc = 0, boot_done = 0;
  cwwt_wait_timer dut (.*);
  initial forever #10 clk_i = ~clk_i;
  // verdict; a leftover note means a halt never ended
  task automatic end_sim;
    if (exp_q.size() > 0) num_errors++;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(int got);
    n_tests++;
    if (got !== exp_q[0]) begin
      num_errors++;
      $display("CHECK FAILED halt_cycles exp %0d got %0d", exp_q[0], got);
    end
    void'(exp_q.pop_front());
  endtask : chk
  task automatic chk_flag(string name, logic e, logic got);
    n_tests++;
    if (got !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %0d got %0d", name, e, got);
    end
  endtask : chk_flag
  // halt length monitor, one result per falling halt, plus per-cycle flag checks
  always @(posedge clk_i) begin
    if (!arst_n_i) begin
      hc = 0;
      m_lat = 0;
      m_svc = 0;
      boot_done = 0;
    end else begin
      chk_flag("periph_halt", boot_done ? 1'b0 : cpu_halt_o, periph_halt_o);
      chk_flag("interrupt_latch", m_lat, interrupt_latch_o);
      chk_flag("irq_service", m_svc, irq_service_o);
      // next expected flags: set beats clear, service only while the cpu runs
      m_svc = m_lat && interrupt_master_enable_i && !cpu_halt_o && !irq_clear_i;
      m_lat = (irq_i && !periph_halt_o) || (m_lat && !irq_clear_i);
      boot_done = boot_done || !cpu_halt_o;
      if (cpu_halt_o === 1'b1) hc++;
      else if (hc > 0) begin
        chk(hc);
        hc = 0;
      end
    end
  end
  // one wake, then random interrupt traffic through the wait
  task automatic wk(int s, int t, int p);
    int n;
    n = (p ? s == 0 : s == t + 1) ? (t ? 8 : 1024) : 0;
    if (n > 0) exp_q.push_back(n + 1);
    wake_source_i <= s[1:0];
    wake_target_i <= t[0];
    pwdn_select_i <= p[0];
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (n + 4) begin
      irq_i <= 1'($urandom);
      irq_clear_i <= 1'($urandom);
      interrupt_master_enable_i <= 1'($urandom);
      @(posedge clk_i);
    end
    $display("test wake %0d %0d %0d done", s, t, p);
  endtask : wk
  // boot wait, then every source, target and select combination
  initial begin
    void'($urandom(32'hf854));
    exp_q.push_back(1026);
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (1030) @(posedge clk_i);
    $display("test reset wait done");
    for (int i = 0; i < 16; i++) wk(i / 4, i / 2 % 2, i % 2);
    end_sim();
  end
  // watchdog, about three times the expected run
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : test_cwwt_wait_timer
bind cwwt_wait_timer cwwt_checker u_chk (.*);
